/* File: core/pmc_pkg.sv */
// Package: modes, subsystem indices, wake source indices and timing constants for the power mode controller
package pmc_pkg;

	// Global power modes, one-hot, highest to lowest consumption
	typedef enum logic [3:0] {
		PMC_ACTIVE    = 4'h1,
		PMC_ALT       = 4'h2,
		PMC_SLEEP     = 4'h4,
		PMC_HIBERNATE = 4'h8
	} pmc_mode_t;

	// Mode-select field codes written by firmware
	localparam logic [1:0] PMC_SEL_ACTIVE    = 2'h0;
	localparam logic [1:0] PMC_SEL_ALT       = 2'h1;
	localparam logic [1:0] PMC_SEL_SLEEP     = 2'h2;
	localparam logic [1:0] PMC_SEL_HIBERNATE = 2'h3;

	// Subsystem enable vector layout
	localparam int          PMC_NSUB     = 8;
	localparam int          PMC_SUB_CPU  = 0;
	localparam logic [7:0]  PMC_TMPL_RST = 8'hFF;

	// Wake source vector layout
	localparam int          PMC_NWAKE        = 7;
	localparam int          PMC_WK_COMP      = 0;
	localparam int          PMC_WK_PIN       = 1;
	localparam int          PMC_WK_I2C       = 2;
	localparam int          PMC_WK_RTC       = 3;
	localparam int          PMC_WK_TIMER     = 4;
	localparam int          PMC_WK_LOW_VOLT  = 5;
	localparam int          PMC_WK_OTHER_IRQ = 6;
	// Sources allowed to wake from sleep: comparator, pin, I2C, RTC, timer, voltage detect
	localparam logic [6:0]  PMC_SLEEP_WAKE_MASK = 7'h3F;
	// Only the pin interrupt unit wakes from hibernate
	localparam logic [6:0]  PMC_HIB_WAKE_MASK   = 7'h02;

	// Regulator enable reset value: both internal regulators on
	localparam logic        PMC_REG_RST = 1'h1;

	// Clock stop follows forced disables by this many cycles
	localparam int          PMC_GATE_NS     = 16;
	localparam int          PMC_CLK_NS      = 8;
	localparam int          PMC_GATE_CYC    = (PMC_GATE_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
	localparam logic [3:0]  PMC_GATE_CYC_W  = 4'(PMC_GATE_CYC);

endpackage : pmc_pkg

/* File: core/pmc_wake_filter.sv */
// Wake filter: qualifies raw wake and reset sources by the current mode
module pmc_wake_filter
	import pmc_pkg::*;
(
	input  wire logic [PMC_NWAKE-1:0] wake_src_i,          // Raw wake requests
	input  wire logic                 external_reset_pin_i, // External reset request
	input  wire logic                 watchdog_reset_i,     // Watchdog reset request
	input  wire logic                 low_voltage_detect_reset_i, // Voltage detect reset request
	input  wire logic [3:0]           mode_i,               // Current mode, one-hot
	output logic                      wake_o,               // Qualified wake
	output logic                      rst_o                 // Qualified reset
);

	logic [PMC_NWAKE-1:0] mask; // Allowed wake sources for mode

	////////////////////////////////////////////////////////////////////////////////
	// Mode-dependent masks
	always_comb begin
		mask  = '1;
		rst_o = external_reset_pin_i | watchdog_reset_i | low_voltage_detect_reset_i;
		if (mode_i == PMC_SLEEP) begin
			mask = PMC_SLEEP_WAKE_MASK;
		end else if (mode_i == PMC_HIBERNATE) begin
			mask  = PMC_HIB_WAKE_MASK;
			rst_o = external_reset_pin_i;
		end
		wake_o = |(wake_src_i & mask);
	end

endmodule : pmc_wake_filter

/* File: core/pmc_top.sv */
// Power mode controller top: mode sequencer, subsystem gating and regulator enables
module pmc_top
	import pmc_pkg::*;
(
	input  wire logic                 clk_sys_i,            // 125 MHz system clock
	input  wire logic                 reset_i,              // Synchronous reset, active high
	input  wire logic [1:0]           mode_sel_i,           // Requested mode code
	input  wire logic                 mode_wr_i,            // Mode write strobe
	input  wire logic [PMC_NSUB-1:0]  active_tmpl_i,        // Active template
	input  wire logic [PMC_NSUB-1:0]  alt_tmpl_i,           // Alternate template
	input  wire logic                 tmpl_wr_i,            // Template write strobe
	input  wire logic                 reg_en_wr_i,          // Regulator enable write strobe
	input  wire logic                 dig_reg_en_i,         // Digital regulator enable value
	input  wire logic                 ana_reg_en_i,         // Analog regulator enable value
	input  wire logic                 io_supply_good_i,     // All io supplies valid
	input  wire logic [PMC_NWAKE-1:0] wake_src_i,           // Wake sources
	input  wire logic                 external_reset_pin_i, // External reset pin
	input  wire logic                 watchdog_reset_i,     // Watchdog reset
	input  wire logic                 low_voltage_detect_reset_i, // Voltage detect reset
	output logic [3:0]                mode_o,               // Current mode, one-hot
	output logic [PMC_NSUB-1:0]       sub_en_o,             // Subsystem enables
	output logic                      clk_run_o,            // Fast clocks running
	output logic                      low_speed_clk_en_o,   // Low-speed osc or watch crystal allowed
	output logic                      dig_reg_en_o,         // Digital regulator enable
	output logic                      ana_reg_en_o,         // Analog regulator enable
	output logic                      reg_buzz_o,           // Core regulators in buzzed state
	output logic                      hib_reg_only_o,       // Only hibernate regulator active
	output logic                      wake_evt_o            // Registered copy of the qualified wake
);

	pmc_mode_t            mode_q;      // Current mode
	logic [PMC_NSUB-1:0]  act_tmpl_q;  // Stored active template
	logic [PMC_NSUB-1:0]  alt_tmpl_q;  // Stored alternate template
	logic                 cpu_force_q; // CPU re-enabled after wake
	logic [3:0]           gate_cnt_q;  // Cycles since forced disables
	logic                 wake;        // Qualified wake
	logic                 rst_evt;     // Qualified reset
	logic                 low_req;     // Legal low-power entry request

	////////////////////////////////////////////////////////////////////////////////
	// Wake source qualification
	pmc_wake_filter u_filter (
		.wake_src_i           (wake_src_i),
		.external_reset_pin_i (external_reset_pin_i),
		.watchdog_reset_i     (watchdog_reset_i),
		.low_voltage_detect_reset_i (low_voltage_detect_reset_i),
		.mode_i               (mode_q),
		.wake_o               (wake),
		.rst_o                (rst_evt)
	);

	// Low-power entry refused while io supplies are not valid; avoids brown pins in sleep
	assign low_req = mode_wr_i & io_supply_good_i
		& (mode_sel_i == PMC_SEL_SLEEP || mode_sel_i == PMC_SEL_HIBERNATE);

	////////////////////////////////////////////////////////////////////////////////
	// Mode sequencer; wake and reset win over a simultaneous write
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			mode_q <= PMC_ACTIVE;
		end else if (wake || rst_evt) begin
			mode_q <= PMC_ACTIVE;
		end else if (mode_wr_i) begin
			case (mode_sel_i)
				PMC_SEL_ACTIVE:    begin mode_q <= PMC_ACTIVE; end
				PMC_SEL_ALT:       begin mode_q <= PMC_ALT; end
				PMC_SEL_SLEEP:     begin if (low_req) mode_q <= PMC_SLEEP; end
				PMC_SEL_HIBERNATE: begin if (low_req) mode_q <= PMC_HIBERNATE; end
				default:           begin mode_q <= mode_q; end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Template storage
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			act_tmpl_q <= PMC_TMPL_RST;
			alt_tmpl_q <= PMC_TMPL_RST;
		end else if (tmpl_wr_i) begin
			act_tmpl_q <= active_tmpl_i;
			alt_tmpl_q <= alt_tmpl_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// CPU force-on after a wake; a later template write hands control back
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cpu_force_q <= 1'h0;
		end else if (wake) begin
			cpu_force_q <= 1'h1;
		end else if (tmpl_wr_i) begin
			cpu_force_q <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Subsystem enables per mode, one flop per bit
	genvar gi;
	generate
		for (gi = 0; gi < PMC_NSUB; gi++) begin : g_sub
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					sub_en_o[gi] <= PMC_TMPL_RST[gi];
				end else if (wake && gi == PMC_SUB_CPU) begin
					sub_en_o[gi] <= 1'h1;
				end else begin
					case (mode_q)
						PMC_ACTIVE: begin
							sub_en_o[gi] <= act_tmpl_q[gi] | (gi == PMC_SUB_CPU && cpu_force_q);
						end
						PMC_ALT:    begin sub_en_o[gi] <= alt_tmpl_q[gi]; end
						default:    begin sub_en_o[gi] <= 1'h0; end
					endcase
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Clock stop sequencing: fast clocks halt only after gates have settled
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			gate_cnt_q <= 4'h0;
			clk_run_o  <= 1'h1;
		end else if (mode_q == PMC_ACTIVE || mode_q == PMC_ALT) begin
			gate_cnt_q <= 4'h0;
			clk_run_o  <= 1'h1;
		end else if (gate_cnt_q < PMC_GATE_CYC_W) begin
			gate_cnt_q <= gate_cnt_q + 4'h1;
			clk_run_o  <= 1'h1;
		end else begin
			clk_run_o  <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock, regulator and wake event status outputs
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			low_speed_clk_en_o <= 1'h1;
			reg_buzz_o         <= 1'h0;
			hib_reg_only_o     <= 1'h0;
			wake_evt_o         <= 1'h0;
		end else begin
			low_speed_clk_en_o <= (mode_q != PMC_HIBERNATE);
			reg_buzz_o         <= (mode_q == PMC_SLEEP);
			hib_reg_only_o     <= (mode_q == PMC_HIBERNATE);
			wake_evt_o         <= wake;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Internal regulator enables, on after reset, firmware may clear
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			dig_reg_en_o <= PMC_REG_RST;
			ana_reg_en_o <= PMC_REG_RST;
		end else if (reg_en_wr_i) begin
			dig_reg_en_o <= dig_reg_en_i;
			ana_reg_en_o <= ana_reg_en_i;
		end
	end

	assign mode_o = mode_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_wake;
		wake;
	endsequence

	sequence s_hib_entered;
		mode_q == PMC_HIBERNATE;
	endsequence

	AST_BOOT_ACTIVE: assert property (@(posedge clk_sys_i) $fell(reset_i) |-> mode_q == PMC_ACTIVE)
		else $error("mode not active after reset");

	AST_WAKE_ACTIVE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		s_wake |=> mode_q == PMC_ACTIVE ##1 sub_en_o[PMC_SUB_CPU])
		else $error("wake did not return active with CPU on");

	AST_SLEEP_OFF: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(mode_q == PMC_SLEEP && !wake) |=> sub_en_o == '0 && reg_buzz_o)
		else $error("sleep left resources on");

	AST_SUPPLY_GATE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(mode_wr_i && !io_supply_good_i && $past(mode_q) == mode_q && mode_q == PMC_ACTIVE)
		|=> mode_q inside {PMC_ACTIVE, PMC_ALT})
		else $error("low power entered without supply good");

	AST_HIB_CLK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		s_hib_entered [*8] |-> !clk_run_o && !low_speed_clk_en_o && hib_reg_only_o)
		else $error("clocks running in hibernate");

	AST_HIB_WAKE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(s_hib_entered and !wake_src_i[PMC_WK_PIN] && !external_reset_pin_i) |=> mode_q == PMC_HIBERNATE)
		else $error("hibernate left without pin event");

	AST_ALT_EXIT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(mode_q == PMC_ALT && |wake_src_i) |=> mode_q == PMC_ACTIVE)
		else $error("interrupt did not exit alternate mode");

	AST_GATE_FIRST: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(mode_q == PMC_SLEEP) |-> clk_run_o ##1 clk_run_o)
		else $error("clocks stopped before gating");

	AST_REG_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!reg_en_wr_i |=> $stable(dig_reg_en_o) && $stable(ana_reg_en_o))
		else $error("regulator enable changed without write");

endmodule : pmc_top

/* File: test/pmc_src_model.sv */
// Wake and reset source model: turns bench requests into one-cycle source pulses
module pmc_src_model
	import pmc_pkg::*;
(
	input  wire logic                 clk_sys_i,  // System clock
	input  wire logic                 reset_i,    // Synchronous reset, active high
	input  wire logic                 req_i,      // Pulse request from the bench
	input  wire logic [3:0]           sel_i,      // 0-6 wake bit, 7 pin reset, 8 watchdog, 9 voltage detect
	output logic      [PMC_NWAKE-1:0] wake_src_o, // Wake source lines
	output logic                      ext_rst_o,  // External reset pin
	output logic                      wdog_rst_o, // Watchdog reset
	output logic                      volt_det_rst_o // Voltage detect reset
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////
	// Sources idle low between pulses, so a stale level never wakes the device twice
	always @(posedge clk_sys_i) begin
		if (!reset_i && req_i) begin
			// Wake sources: comparator, pin unit, I2C, RTC, timer, voltage detect, other irq
			wake_src_o     <= (sel_i < 4'h7) ? (PMC_NWAKE'(1) << sel_i[2:0]) : '0;
			ext_rst_o      <= (sel_i == 4'h7);
			wdog_rst_o     <= (sel_i == 4'h8);
			volt_det_rst_o <= (sel_i == 4'h9);
		end else begin
			wake_src_o     <= '0;
			ext_rst_o      <= 1'b0;
			wdog_rst_o     <= 1'b0;
			volt_det_rst_o <= 1'b0;
		end
	end

endmodule : pmc_src_model

/* File: test/tb_pmc_top.sv */
// Testbench for the power mode controller: mode entry, gating, wake filtering and regulators
module tb_pmc_top
	import pmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {int id; logic [7:0] exp;} pmc_note_t;
	logic                clk_sys_i = 1'b0;
	logic                reset_i = 1'b1;
	logic [1:0]          mode_sel_i = 2'h0;
	logic                mode_wr_i = 1'b0, tmpl_wr_i = 1'b0, reg_en_wr_i = 1'b0;
	logic [PMC_NSUB-1:0] active_tmpl_i = 8'hFF, alt_tmpl_i = 8'hFF;
	logic                dig_reg_en_i = 1'b1, ana_reg_en_i = 1'b1, io_supply_good_i = 1'b1;
	logic                req = 1'b0;                // Request to the source model
	logic [3:0]          sel = 4'h0;                // Source picked by the request
	logic [PMC_NWAKE-1:0] wake_src;
	logic                ext_rst, wdog_rst, volt_det_rst;
	logic [3:0]          mode_o;
	logic [PMC_NSUB-1:0] sub_en_o;
	logic                clk_run_o, low_speed_clk_en_o, dig_reg_en_o, ana_reg_en_o;
	logic                reg_buzz_o, hib_reg_only_o, wake_evt_o;
	int                  seed = 48858;
	int                  mismatches = 0;
	int                  checked = 0;
	pmc_note_t           notes[$];                  // Expected results, oldest first
	string names[9] = '{"mode", "sub_en", "clk_run", "low_speed", "dig_reg", "ana_reg", "buzz", "hib_reg", "wake_evt"};
	logic [7:0] rst_exp[9] = '{8'h01, 8'hFF, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

	always #4 clk_sys_i = ~clk_sys_i;

	pmc_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mode_sel_i(mode_sel_i), .mode_wr_i(mode_wr_i),
		.active_tmpl_i(active_tmpl_i), .alt_tmpl_i(alt_tmpl_i), .tmpl_wr_i(tmpl_wr_i), .reg_en_wr_i(reg_en_wr_i),
		.dig_reg_en_i(dig_reg_en_i), .ana_reg_en_i(ana_reg_en_i), .io_supply_good_i(io_supply_good_i),
		.wake_src_i(wake_src), .external_reset_pin_i(ext_rst), .watchdog_reset_i(wdog_rst),
		.low_voltage_detect_reset_i(volt_det_rst),
		.mode_o(mode_o), .sub_en_o(sub_en_o), .clk_run_o(clk_run_o), .low_speed_clk_en_o(low_speed_clk_en_o),
		.dig_reg_en_o(dig_reg_en_o), .ana_reg_en_o(ana_reg_en_o), .reg_buzz_o(reg_buzz_o),
		.hib_reg_only_o(hib_reg_only_o), .wake_evt_o(wake_evt_o));

	pmc_src_model u_src (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req), .sel_i(sel),
		.wake_src_o(wake_src), .ext_rst_o(ext_rst), .wdog_rst_o(wdog_rst), .volt_det_rst_o(volt_det_rst));

	////////////////////////////////////////////////////////////////////////////
	// Output picked by a note id, zero extended to the note width
	function automatic logic [7:0] obs(input int id);
		case (id)
			0: return {4'h0, mode_o};
			1: return sub_en_o;
			2: return {7'h0, clk_run_o};
			3: return {7'h0, low_speed_clk_en_o};
			4: return {7'h0, dig_reg_en_o};
			5: return {7'h0, ana_reg_en_o};
			6: return {7'h0, reg_buzz_o};
			7: return {7'h0, hib_reg_only_o};
			default: return {7'h0, wake_evt_o};
		endcase
	endfunction : obs

	// Checker: mid-cycle, when outputs are settled, each pending note is compared
	always @(negedge clk_sys_i) begin : mon
		pmc_note_t n;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			checked++;
			if (obs(n.id) !== n.exp) begin
				$display("ERROR %s expected %h seen %h", names[n.id], n.exp, obs(n.id));
				mismatches++;
			end
		end
	end

	task automatic end_of_test();
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////
	// Drivers: inputs always change 1 ns after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc

	task automatic chk(input int id, input logic [7:0] exp);
		notes.push_back('{id, exp});
	endtask : chk

	task automatic wr_mode(input logic [1:0] s);
		mode_sel_i = s;
		mode_wr_i  = 1'b1;
		cyc(1);
		mode_wr_i  = 1'b0;
	endtask : wr_mode

	// Source pulse reaches the design one edge after the request, taken at the next
	task automatic fire(input logic [3:0] s);
		sel = s;
		req = 1'b1;
		cyc(1);
		req = 1'b0;
		cyc(1);
	endtask : fire

	// Low-power entry: gating lands one cycle after the mode, clocks stop two later
	task automatic enter_low(input logic [1:0] s);
		wr_mode(s);
		chk(0, (s == PMC_SEL_SLEEP) ? {4'h0, PMC_SLEEP} : {4'h0, PMC_HIBERNATE});
		cyc(1);
		chk(1, 8'h00);
		chk(6, {7'h0, s == PMC_SEL_SLEEP});
		chk(7, {7'h0, s == PMC_SEL_HIBERNATE});
		chk(3, {7'h0, s == PMC_SEL_SLEEP});
		cyc(1);
		chk(2, 8'h01);
		cyc(1);
		chk(2, 8'h00);
	endtask : enter_low

	task automatic wake_ok(input logic [3:0] s);
		fire(s);
		chk(0, {4'h0, PMC_ACTIVE});
		chk(8, 8'h01);
		cyc(1);
		chk(1, active_tmpl_i | 8'h01);
		chk(8, 8'h00);
	endtask : wake_ok

	task automatic wake_no(input logic [3:0] s, input logic [7:0] m);
		fire(s);
		cyc(1);
		chk(0, m);
		chk(8, 8'h00);
	endtask : wake_no

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		cyc(2);
		reset_i = 1'b0;
		foreach (rst_exp[i]) chk(i, rst_exp[i]);
		// CPU bit cleared in the template so the forced CPU enable on wake is visible
		active_tmpl_i = 8'($random(seed)) & 8'hFE;
		alt_tmpl_i    = 8'($random(seed));
		tmpl_wr_i = 1'b1;
		cyc(1);
		tmpl_wr_i = 1'b0;
		cyc(2);
		chk(1, active_tmpl_i);
		wr_mode(PMC_SEL_ALT);
		chk(0, {4'h0, PMC_ALT});
		cyc(1);
		chk(1, alt_tmpl_i);
		wake_ok(4'h6);
		// Low-power writes refused while io supplies are not valid
		io_supply_good_i = 1'b0;
		for (int i = 2; i < 4; i++) begin
			wr_mode(2'(i));
			cyc(1);
			chk(0, {4'h0, PMC_ACTIVE});
		end
		io_supply_good_i = 1'b1;
		for (int i = 0; i < 6; i++) begin
			enter_low(PMC_SEL_SLEEP);
			wake_ok(4'(i));
		end
		enter_low(PMC_SEL_SLEEP);
		wake_no(4'h6, {4'h0, PMC_SLEEP});
		fire(4'h8);
		chk(0, {4'h0, PMC_ACTIVE});
		enter_low(PMC_SEL_HIBERNATE);
		for (int i = 0; i < 10; i++) if (i != 1 && i != 7) wake_no(4'(i), {4'h0, PMC_HIBERNATE});
		wake_ok(4'h1);
		enter_low(PMC_SEL_HIBERNATE);
		fire(4'h7);
		chk(0, {4'h0, PMC_ACTIVE});
		// Wake lands on the same edge as a sleep write and wins
		wr_mode(PMC_SEL_ALT);
		sel = 4'h6;
		req = 1'b1;
		cyc(1);
		req = 1'b0;
		mode_sel_i = PMC_SEL_SLEEP;
		mode_wr_i  = 1'b1;
		cyc(1);
		mode_wr_i  = 1'b0;
		chk(0, {4'h0, PMC_ACTIVE});
		// Active re-entered by a plain write, then by a reset source while in alternate
		wr_mode(PMC_SEL_ALT);
		cyc(1);
		wr_mode(PMC_SEL_ACTIVE);
		chk(0, {4'h0, PMC_ACTIVE});
		cyc(1);
		wr_mode(PMC_SEL_ALT);
		fire(4'h9);
		chk(0, {4'h0, PMC_ACTIVE});
		// A template write hands the CPU bit back to firmware after a wake forced it on
		active_tmpl_i = 8'($random(seed)) & 8'hFE;
		tmpl_wr_i = 1'b1;
		cyc(1);
		tmpl_wr_i = 1'b0;
		cyc(1);
		chk(1, active_tmpl_i);
		// Strobe held high across the loop, one new value pair each edge, ending with both off
		reg_en_wr_i = 1'b1;
		for (int i = 0; i < 4; i++) begin
			{dig_reg_en_i, ana_reg_en_i} = 2'(3 - i);
			cyc(1);
			chk(4, {7'h0, dig_reg_en_i});
			chk(5, {7'h0, ana_reg_en_i});
		end
		reg_en_wr_i = 1'b0;
		// Reset in mid-run from sleep brings back boot mode and regulator defaults
		enter_low(PMC_SEL_SLEEP);
		reset_i = 1'b1;
		cyc(2);
		reset_i = 1'b0;
		foreach (rst_exp[i]) chk(i, rst_exp[i]);
		cyc(2);
		end_of_test();
	end

	// Watchdog: the whole sequence needs well under 300 cycles
	initial begin
		#20000;
		mismatches++;
		end_of_test();
	end

endmodule : tb_pmc_top
